// ==== rtl/sqm_top.sv ====
// Chosen here: the per-mode bit periods and the APB slave port; the register offsets come from the constants header.
`include "sqm_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sqm_top
#(
  parameter bit ENHANCED   = 1'b1,
  parameter int MS_CYCLES  = `SQM_CLK_HZ / `SQM_MS_PER_S
)
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  pinIn,
  output logic             irq,
  output logic             busy
);
  import sqm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // bit periods keep their 4 MHz cycle count, so rate tracks the clock
  localparam logic [15:0] CYC0 = 16'(`SQM_REF_HZ / `SQM_BAUD0);
  localparam logic [15:0] CYC1 = 16'(`SQM_REF_HZ / `SQM_BAUD1);
  localparam logic [15:0] CYC2 = 16'(`SQM_REF_HZ / `SQM_BAUD2);
  localparam logic [15:0] CYC3 = 16'(`SQM_REF_HZ / `SQM_BAUD3);
  localparam logic [17:0] MS_LAST = 18'(MS_CYCLES - 1);

  logic [7:0]  pinS1_r;
  logic [7:0]  pinS2_r;
  logic [2:0]  pinSel_r;
  logic [2:0]  mode_r;
  logic [2:0]  qualCnt_r;
  logic        decMode_r;
  logic        tmoEn_r;
  sqm_byte_t   qual_r [0:3];
  logic [15:0] tmoMs_r;
  sqm_byte_t   data_r;
  logic        tmoFlag_r;
  logic        frameFlag_r;
  logic [2:0]  intStat_r;
  logic [2:0]  intMask_r;
  sqm_ctl_e    state_r;
  logic [1:0]  qIdx_r;
  logic        waiting_r;
  logic [17:0] cycCnt_r;
  logic [15:0] msCnt_r;
  logic        evDone;
  logic        evTmo;
  logic        evMiss;
  logic        wrStrobe;
  logic        rdStrobe;
  logic        goReq;
  logic        decDone;
  logic [7:0]  decValue;
  logic [31:0] rdMux;
  logic        rdHit;

  sqm_bit_if bitBus ();

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: second stage is the only reader of the first
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pinS1_r <= 8'h00;
      pinS2_r <= 8'h00;
    end
    else
    begin
      pinS1_r <= pinIn;
      pinS2_r <= pinS1_r;
    end
  end

  assign bitBus.enable    = (state_r != ctlIdle);
  assign bitBus.lineLevel = pinS2_r[pinSel_r] ^ mode_r[`SQM_MODE_INV_BIT];

  always_comb
  begin
    unique case (mode_r[1:0])
      2'h0:    bitBus.bitCycles = CYC0;
      2'h1:    bitBus.bitCycles = CYC1;
      2'h2:    bitBus.bitCycles = CYC2;
      2'h3:    bitBus.bitCycles = CYC3;
    endcase
  end

  sqm_rx_bit uRx
  (
    .clock (clock),
    .rst   (rst),
    .bus   (bitBus.rx)
  );

  sqm_dec_conv uDec
  (
    .clock   (clock),
    .rst     (rst),
    .clear   (goReq),
    .inValid (bitBus.byteValid && (state_r == ctlPayload) && decMode_r),
    .inByte  (bitBus.byteData),
    .value   (decValue),
    .done    (decDone)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // apb: one wait state, so data and pready both come from flops
  assign wrStrobe = psel && penable && pready && pwrite;
  assign rdStrobe = psel && penable && !pready;
  assign goReq    = wrStrobe && (paddr == `SQM_ADDR_GO) && pwdata[0] && (state_r == ctlIdle);

  always_comb
  begin
    rdHit = 1'b1;
    rdMux = 32'h0000_0000;
    unique case (paddr)
      `SQM_ADDR_CTRL:
      begin
        rdMux[`SQM_CTRL_PIN_LSB +: 3]  = pinSel_r;
        rdMux[`SQM_CTRL_MODE_LSB +: 3] = mode_r;
        rdMux[`SQM_CTRL_QCNT_LSB +: 3] = qualCnt_r;
        rdMux[`SQM_CTRL_DEC_BIT]       = decMode_r;
        rdMux[`SQM_CTRL_TMO_BIT]       = tmoEn_r;
      end
      `SQM_ADDR_GO:      rdMux = 32'h0000_0000;
      `SQM_ADDR_QUAL:    rdMux = {qual_r[3], qual_r[2], qual_r[1], qual_r[0]};
      `SQM_ADDR_TMO:     rdMux[15:0] = tmoMs_r;
      `SQM_ADDR_DATA:    rdMux[7:0] = data_r;
      `SQM_ADDR_STAT:    rdMux[2:0] = {frameFlag_r, tmoFlag_r, busy};
      `SQM_ADDR_INTSTAT: rdMux[2:0] = intStat_r;
      `SQM_ADDR_INTMASK: rdMux[2:0] = intMask_r;
      default:           rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= rdStrobe;
      // writes are never refused, only unmapped reads
      pslverr <= rdStrobe && !pwrite && !rdHit;
      if (rdStrobe)
        prdata <= rdHit ? rdMux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration is frozen while a request is pending
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pinSel_r  <= 3'h0;
      mode_r    <= 3'h0;
      qualCnt_r <= 3'h0;
      decMode_r <= 1'b0;
      tmoEn_r   <= 1'b0;
      tmoMs_r   <= 16'h0000;
      intMask_r <= 3'h0;
    end
    else if (wrStrobe && (state_r == ctlIdle))
    begin
      if (paddr == `SQM_ADDR_CTRL)
      begin
        pinSel_r  <= pwdata[`SQM_CTRL_PIN_LSB +: 3];
        mode_r    <= pwdata[`SQM_CTRL_MODE_LSB +: 3];
        qualCnt_r <= (pwdata[`SQM_CTRL_QCNT_LSB +: 3] > 3'(`SQM_QUAL_MAX))
                     ? 3'(`SQM_QUAL_MAX) : pwdata[`SQM_CTRL_QCNT_LSB +: 3];
        decMode_r <= pwdata[`SQM_CTRL_DEC_BIT];
        tmoEn_r   <= pwdata[`SQM_CTRL_TMO_BIT] && ENHANCED;
      end
      if (paddr == `SQM_ADDR_TMO)
        tmoMs_r <= pwdata[15:0];
      if (paddr == `SQM_ADDR_INTMASK)
        intMask_r <= pwdata[2:0];
    end
  end

  genvar gq;
  generate
    for (gq = 0; gq < `SQM_QUAL_MAX; gq++)
    begin : gQual
      always_ff @(posedge clock)
      begin
        if (rst)
          qual_r[gq] <= 8'h00;
        else if (wrStrobe && (state_r == ctlIdle) && (paddr == `SQM_ADDR_QUAL))
          qual_r[gq] <= pwdata[8*gq +: 8];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // receive sequencing
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_r <= ctlIdle;
      qIdx_r  <= 2'h0;
      busy    <= 1'b0;
      data_r  <= 8'h00;
      evDone  <= 1'b0;
      evMiss  <= 1'b0;
    end
    else
    begin
      evDone <= 1'b0;
      evMiss <= 1'b0;
      unique case (state_r)
        ctlIdle:
          if (goReq)
          begin
            state_r <= (qualCnt_r == 3'h0) ? ctlPayload : ctlHunt;
            qIdx_r  <= 2'h0;
            busy    <= 1'b1;
          end
        ctlHunt:
          if (evTmo)
          begin
            state_r <= ctlIdle;
            busy    <= 1'b0;
          end
          else if (bitBus.byteValid)
          begin
            if (bitBus.byteData == qual_r[qIdx_r])
            begin
              if ({1'b0, qIdx_r} == qualCnt_r - 3'h1)
                state_r <= ctlPayload;
              else
                qIdx_r <= qIdx_r + 2'h1;
            end
            else
            begin
              evMiss <= 1'b1;
              // the breaking byte may itself open a fresh sequence
              qIdx_r <= (bitBus.byteData == qual_r[0]) ? 2'h1 : 2'h0;
            end
          end
        ctlPayload:
          if (evTmo)
          begin
            state_r <= ctlIdle;
            busy    <= 1'b0;
          end
          else if ((!decMode_r && bitBus.byteValid) || (decMode_r && decDone))
          begin
            data_r  <= decMode_r ? decValue : bitBus.byteData;
            evDone  <= 1'b1;
            state_r <= ctlIdle;
            busy    <= 1'b0;
          end
        default:
          state_r <= ctlIdle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // timeout covers only the wait for the first start bit
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      waiting_r <= 1'b0;
      cycCnt_r  <= 18'h00000;
      msCnt_r   <= 16'h0000;
      evTmo     <= 1'b0;
    end
    else if (goReq)
    begin
      waiting_r <= tmoEn_r;
      cycCnt_r  <= 18'h00000;
      msCnt_r   <= 16'h0000;
      evTmo     <= 1'b0;
    end
    else
    begin
      evTmo <= 1'b0;
      if (bitBus.startSeen || state_r == ctlIdle || evTmo)
        waiting_r <= 1'b0;
      else if (waiting_r)
      begin
        if (msCnt_r >= tmoMs_r)
        begin
          evTmo     <= 1'b1;
          waiting_r <= 1'b0;
        end
        else if (cycCnt_r == MS_LAST)
        begin
          cycCnt_r <= 18'h00000;
          msCnt_r  <= msCnt_r + 16'h0001;
        end
        else
          cycCnt_r <= cycCnt_r + 18'h00001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky flags: a new event wins over a same-cycle intstat clear; go wins over it for the tmo and frame flags
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      intStat_r   <= 3'h0;
      tmoFlag_r   <= 1'b0;
      frameFlag_r <= 1'b0;
      irq         <= 1'b0;
    end
    else
    begin
      intStat_r <= (intStat_r
                   & ~((wrStrobe && paddr == `SQM_ADDR_INTSTAT) ? pwdata[2:0] : 3'h0))
                   | {evMiss, evTmo, evDone};
      if (goReq)
        tmoFlag_r <= 1'b0;
      else if (evTmo)
        tmoFlag_r <= 1'b1;
      if (goReq)
        frameFlag_r <= 1'b0;
      else if (bitBus.frameErr)
        frameFlag_r <= 1'b1;
      irq <= |(intStat_r & intMask_r);
    end
  end
endmodule : sqm_top
`default_nettype wire

// ==== rtl/sqm_consts.svh ====
`ifndef SQM_CONSTS_SVH
`define SQM_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
`define SQM_ADDR_CTRL     8'h00
`define SQM_ADDR_GO       8'h04
`define SQM_ADDR_QUAL     8'h08
`define SQM_ADDR_TMO      8'h0c
`define SQM_ADDR_DATA     8'h10
`define SQM_ADDR_STAT     8'h14
`define SQM_ADDR_INTSTAT  8'h18
`define SQM_ADDR_INTMASK  8'h1c

`define SQM_CTRL_PIN_LSB  0
`define SQM_CTRL_MODE_LSB 4
`define SQM_CTRL_QCNT_LSB 8
`define SQM_CTRL_DEC_BIT  12
`define SQM_CTRL_TMO_BIT  13
`define SQM_MODE_INV_BIT  2

`define SQM_INT_DONE      0
`define SQM_INT_TMO       1
`define SQM_INT_MISS      2

`define SQM_REF_HZ        4000000
`define SQM_BAUD0         300
`define SQM_BAUD1         600
`define SQM_BAUD2         1200
`define SQM_BAUD3         2400
`define SQM_CLK_HZ        125000000
`define SQM_MS_PER_S      1000
`define SQM_QUAL_MAX      4
`endif

// ==== rtl/sqm_pkg.sv ====
package sqm_pkg;
  typedef logic [7:0] sqm_byte_t;
  typedef enum logic [1:0] {rxIdle, rxStart, rxData, rxStop} sqm_rx_e;
  typedef enum logic [1:0] {ctlIdle, ctlHunt, ctlPayload} sqm_ctl_e;
endpackage : sqm_pkg

// ==== rtl/sqm_bit_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sqm_bit_if;
  logic        enable;
  logic [15:0] bitCycles;
  logic        lineLevel;
  logic        startSeen;
  logic        byteValid;
  logic [7:0]  byteData;
  logic        frameErr;
  modport rx  (input enable, bitCycles, lineLevel, output startSeen, byteValid, byteData, frameErr);
  modport ctl (output enable, bitCycles, lineLevel, input startSeen, byteValid, byteData, frameErr);
endinterface : sqm_bit_if
`default_nettype wire

// ==== rtl/sqm_rx_bit.sv ====
`timescale 1ns/1ps
`default_nettype none
module sqm_rx_bit
(
  input  wire logic clock,
  input  wire logic rst,
  sqm_bit_if.rx     bus
);
  import sqm_pkg::*;
  sqm_rx_e     state_r;
  logic [15:0] cnt_r;
  logic [2:0]  bitIdx_r;
  logic [7:0]  shift_r;

  always_ff @(posedge clock)
  begin
    if (rst || !bus.enable)
    begin
      state_r       <= rxIdle;
      cnt_r         <= 16'h0000;
      bitIdx_r      <= 3'h0;
      shift_r       <= 8'h00;
      bus.startSeen <= 1'b0;
      bus.byteValid <= 1'b0;
      bus.frameErr  <= 1'b0;
      bus.byteData  <= 8'h00;
    end
    else
    begin
      bus.startSeen <= 1'b0;
      bus.byteValid <= 1'b0;
      bus.frameErr  <= 1'b0;
      unique case (state_r)
        rxIdle:
          if (!bus.lineLevel)
          begin
            state_r <= rxStart;
            cnt_r   <= bus.bitCycles >> 1;
          end
        rxStart:
          if (cnt_r != 16'h0000)
            cnt_r <= cnt_r - 16'h0001;
          else if (!bus.lineLevel)
          begin
            // glitch shorter than half a bit falls back to idle
            state_r       <= rxData;
            bus.startSeen <= 1'b1;
            cnt_r         <= bus.bitCycles - 16'h0001;
            bitIdx_r      <= 3'h0;
          end
          else
            state_r <= rxIdle;
        rxData:
          if (cnt_r != 16'h0000)
            cnt_r <= cnt_r - 16'h0001;
          else
          begin
            shift_r  <= {bus.lineLevel, shift_r[7:1]};
            cnt_r    <= bus.bitCycles - 16'h0001;
            bitIdx_r <= bitIdx_r + 3'h1;
            if (bitIdx_r == 3'h7)
              state_r <= rxStop;
          end
        rxStop:
          if (cnt_r != 16'h0000)
            cnt_r <= cnt_r - 16'h0001;
          else
          begin
            bus.byteValid <= bus.lineLevel;
            bus.frameErr  <= !bus.lineLevel;
            bus.byteData  <= shift_r;
            state_r       <= rxIdle;
          end
      endcase
    end
  end
endmodule : sqm_rx_bit
`default_nettype wire

// ==== rtl/sqm_dec_conv.sv ====
`timescale 1ns/1ps
`default_nettype none
module sqm_dec_conv
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              clear,
  input  wire logic              inValid,
  input  wire sqm_pkg::sqm_byte_t inByte,
  output logic      [7:0]        value,
  output logic                   done
);
  import sqm_pkg::*;
  logic       gotDigit_r;
  logic       isDigit;
  logic [7:0] digit;

  assign isDigit = (inByte >= 8'h30) && (inByte <= 8'h39);
  assign digit   = inByte - 8'h30;

  // value wraps modulo 256; leading non-digits are skipped
  always_ff @(posedge clock)
  begin
    if (rst || clear)
    begin
      value      <= 8'h00;
      done       <= 1'b0;
      gotDigit_r <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (inValid && isDigit)
      begin
        value      <= 8'((value * 8'd10) + digit);
        gotDigit_r <= 1'b1;
      end
      else if (inValid && gotDigit_r)
      begin
        done       <= 1'b1;
        gotDigit_r <= 1'b0;
      end
    end
  end
endmodule : sqm_dec_conv
`default_nettype wire

// ==== verif/sqm_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module sqm_asserts
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  pinIn,
  input wire logic        irq,
  input wire logic        busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  sequence accWait;
    psel && penable && !pready;
  endsequence
  sequence rdDone;
    psel && penable && pready && !pwrite;
  endsequence
  ready_wait_a: assert property (accWait |=> pready)
    else $error("pready not one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  write_ok_a: assert property (pready && pwrite |-> !pslverr)
    else $error("write answered with error");
  unmapped_err_a: assert property (rdDone ##0 paddr > 8'h1c |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  go_zero_a: assert property (rdDone ##0 paddr == 8'h04 |-> prdata == 32'h0)
    else $error("go register read not zero");
  data_width_a: assert property (rdDone ##0 paddr == 8'h10 |-> prdata[31:8] == 24'h0)
    else $error("data wider than a byte");
  busy_start_a: assert property ($rose(busy) |->
    $past(psel && penable && pready && pwrite && paddr == 8'h04 && pwdata[0]))
    else $error("busy rose without go");
endmodule : sqm_asserts
bind sqm_top sqm_asserts u_chk (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pinIn(pinIn), .irq(irq), .busy(busy));
`default_nettype wire

// ==== verif/sqm_uart_tx.sv ====
`timescale 1ns/1ps
`default_nettype none
module sqm_uart_tx
(
  input  wire logic clock,
  output logic      line
);
  // mode 3 bit time; a slower partner just raises this
  int   bitCycles = 1666;
  logic inv       = 1'b0;
  initial line = 1'b1;
  //////////////////////////////////////////////////////////////////////////////
  task automatic setPol(input logic i);
    inv = i;
    line <= ~i;
  endtask : setPol
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++)
    begin
      line <= f[k] ^ inv;
      repeat (bitCycles) @(posedge clock);
    end
  endtask : send
endmodule : sqm_uart_tx
`default_nettype wire

// ==== verif/sqm_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module sqm_tb_top;
  logic        clock   = 1'b0;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pinIn;
  logic        irq;
  logic        busy;
  logic        txLine;
  logic [2:0]  pinSel  = 3'h2;
  logic [31:0] rd;
  logic        slvErr;
  int          errTotal  = 0;
  int          numChecks = 0;
  always #4 clock = ~clock;
  // unselected pins sit at the active level so a wrong pick shows
  always_comb
  begin
    pinIn         = {8{~txLine}};
    pinIn[pinSel] = txLine;
  end
  sqm_top #(.MS_CYCLES(20)) dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinIn(pinIn), .irq(irq), .busy(busy));
  sqm_uart_tx tx (.clock(clock), .line(txLine));
  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d errors %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd     = prdata;
    slvErr = pslverr;
    if (n >= 20)
    begin
      errTotal++;
      report_and_stop();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask : rdChk
  task automatic waitIdle(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < lim)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= lim)
    begin
      errTotal++;
      report_and_stop();
    end
  endtask : waitIdle
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst     <= 1'b1;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 8'h00;
    pwdata  <= 32'h0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdChk("intstat", 8'h18, 32'h0);
    chk("busy", busy, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", slvErr, 32'h1);
    rdChk("go", 8'h04, 32'h0);
    $display("test reset done");
    wr(8'h1c, 32'h1);
    wr(8'h00, 32'h32);
    wr(8'h04, 32'h1);
    chk("busy", busy, 32'h1);
    tx.send(8'ha5);
    waitIdle(200);
    rdChk("data", 8'h10, 32'ha5);
    rdChk("intstat", 8'h18, 32'h1);
    chk("irq", irq, 32'h1);
    wr(8'h18, 32'h7);
    repeat (2) @(posedge clock);
    chk("irq", irq, 32'h0);
    $display("test plain byte done");
    tx.setPol(1'b1);
    pinSel <= 3'h5;
    wr(8'h08, 32'h47);
    wr(8'h1c, 32'h4);
    wr(8'h00, 32'h1175);
    wr(8'h04, 32'h1);
    tx.send(8'h11);
    rdChk("intstat", 8'h18, 32'h4);
    chk("irq", irq, 32'h1);
    rdChk("data", 8'h10, 32'ha5);
    tx.send(8'h47);
    tx.send(8'h39);
    chk("busy", busy, 32'h1);
    tx.send(8'h20);
    waitIdle(200);
    rdChk("data", 8'h10, 32'h9);
    $display("test qualifier done");
    tx.setPol(1'b0);
    wr(8'h18, 32'h7);
    wr(8'h1c, 32'h2);
    wr(8'h0c, 32'h3);
    wr(8'h00, 32'h2035);
    wr(8'h04, 32'h1);
    // 3 ms at 20 cycles each
    repeat (40) @(posedge clock);
    chk("busy", busy, 32'h1);
    waitIdle(100);
    rdChk("stat", 8'h14, 32'h2);
    rdChk("intstat", 8'h18, 32'h2);
    rdChk("data", 8'h10, 32'h9);
    chk("irq", irq, 32'h1);
    $display("test timeout done");
    report_and_stop();
  end
endmodule : sqm_tb_top
`default_nettype wire
